// ===== rtl/mppc_defines.vh
// Register map, field positions, reset values and timing counts for the PHY management and pause block.
`ifndef MPPC_DEFINES_VH
`define MPPC_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define MPPC_IDX_ACCESS       6'h06
`define MPPC_IDX_DATA         6'h07
`define MPPC_IDX_FLOW         6'h08

`define MPPC_RST_ACCESS       32'h0000_0000
`define MPPC_RST_DATA         32'h0000_0000
`define MPPC_RST_FLOW         32'h0000_0000

`define MPPC_ACC_PHY_HI       15
`define MPPC_ACC_PHY_LO       11
`define MPPC_ACC_IDX_HI       10
`define MPPC_ACC_IDX_LO       6
`define MPPC_ACC_WR_BIT       1
`define MPPC_ACC_BUSY_BIT     0
`define MPPC_DATA_HI          15
`define MPPC_FLOW_PT_HI       31
`define MPPC_FLOW_PT_LO       16
`define MPPC_FLOW_PASS_BIT    2
`define MPPC_FLOW_EN_BIT      1
`define MPPC_FLOW_BUSY_BIT    0

`define MPPC_INT_PHY_ADDR     5'h01

// Times in ns, with cycle counts derived from the 20 ns clock period.
`define MPPC_CLK_NS           20
`define MPPC_SLOT_NS          5120
`define MPPC_SLOT_CYC         ((`MPPC_SLOT_NS + `MPPC_CLK_NS - 1) / `MPPC_CLK_NS)
`define MPPC_MDC_PERIOD_NS    400
`define MPPC_MDC_HALF_CYC     ((`MPPC_MDC_PERIOD_NS / 2 + `MPPC_CLK_NS - 1) / `MPPC_CLK_NS)

`endif

// ===== rtl/mppc_mdio.v
// Serial management frame engine: shifts out one 64-bit management frame per start pulse.
`include "mppc_defines.vh"

module mppc_mdio #(
   parameter HALF_CYC = `MPPC_MDC_HALF_CYC
)(
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire        i_start,
   input  wire        i_wr,
   input  wire [4:0]  i_phy,
   input  wire [4:0]  i_reg,
   input  wire [15:0] i_wdata,
   input  wire        i_mdi,
   output reg         o_done,
   output reg  [15:0] o_rdata,
   output reg         o_mdc,
   output reg         o_mdo,
   output reg         o_mdo_oe
);

   reg        run_ff;
   reg        wr_ff;
   reg [63:0] sh_ff;
   reg [5:0]  bitn_ff;
   reg [15:0] div_ff;

   // Frame: preamble, start, opcode, PHY address, register, turnaround, data.
   wire [63:0] frame = {32'hFFFF_FFFF, 2'b01, (i_wr ? 2'b01 : 2'b10),
                        i_phy, i_reg, 2'b10, i_wdata};
   wire        tick  = (div_ff == HALF_CYC[15:0] - 16'h0001);

   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         run_ff   <= 1'b0;
         wr_ff    <= 1'b0;
         sh_ff    <= 64'h0000_0000_0000_0000;
         bitn_ff  <= 6'h00;
         div_ff   <= 16'h0000;
         o_done   <= 1'b0;
         o_rdata  <= 16'h0000;
         o_mdc    <= 1'b0;
         o_mdo    <= 1'b0;
         o_mdo_oe <= 1'b0;
      end
      else
      begin
         o_done <= 1'b0;
         if (!run_ff)
         begin
            div_ff <= 16'h0000;
            if (i_start)
            begin
               run_ff   <= 1'b1;
               wr_ff    <= i_wr;
               sh_ff    <= frame;
               bitn_ff  <= 6'h00;
               o_mdo    <= frame[63];
               o_mdo_oe <= 1'b1;
               o_mdc    <= 1'b0;
            end
         end
         else
         begin
            div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
            if (tick && !o_mdc)
            begin
               o_mdc <= 1'b1;
               // The PHY drives read data from bit 48 on; sampled on the rising edge.
               if (!wr_ff && bitn_ff >= 6'h30)
                  o_rdata <= {o_rdata[14:0], i_mdi};
            end
            else if (tick)
            begin
               o_mdc <= 1'b0;
               if (bitn_ff == 6'h3F)
               begin
                  run_ff   <= 1'b0;
                  o_done   <= 1'b1;
                  o_mdo    <= 1'b0;
                  o_mdo_oe <= 1'b0;
               end
               else
               begin
                  bitn_ff  <= bitn_ff + 6'h01;
                  sh_ff    <= {sh_ff[62:0], 1'b0};
                  o_mdo    <= sh_ff[62];
                  // Release the line at turnaround so the PHY can answer a read.
                  o_mdo_oe <= wr_ff || (bitn_ff < 6'h2D);
               end
            end
         end
      end
   end

endmodule

// ===== rtl/mppc_top.v
// PHY management access and pause flow control registers behind an AHB-Lite slave.
//
// The AHB-Lite slave port was chosen for this implementation.
`include "mppc_defines.vh"

module mppc_top #(
   parameter SLOT_CYC = `MPPC_SLOT_CYC,
   parameter MDC_HALF = `MPPC_MDC_HALF_CYC
)(
   input  wire        I_CLK,
   input  wire        I_SYS_RST,
   input  wire        I_HSEL,
   input  wire [31:0] I_HADDR,
   input  wire [1:0]  I_HTRANS,
   input  wire        I_HWRITE,
   input  wire [2:0]  I_HSIZE,
   input  wire [31:0] I_HWDATA,
   input  wire        I_HREADY,
   output reg         O_HREADYOUT,
   output reg  [31:0] O_HRDATA,
   output reg         O_HRESP,
   output reg         O_EXT_MDC,
   output reg         O_EXT_MDIO_O,
   output reg         O_EXT_MDIO_OE,
   input  wire        I_EXT_MDIO_I,
   output reg         O_INT_MDC,
   output reg         O_INT_MDIO_O,
   output reg         O_INT_MDIO_OE,
   input  wire        I_INT_MDIO_I,
   input  wire        I_FULL_DUPLEX,
   input  wire        I_TX_ENABLE,
   input  wire        I_FLOW_REQ,
   output reg         O_PAUSE_TX_REQ,
   output reg  [15:0] O_PAUSE_TIME,
   input  wire        I_PAUSE_TX_DONE,
   output reg         O_BACKPRESSURE,
   output reg         O_TX_HOLD,
   input  wire [7:0]  I_RX_DATA,
   input  wire        I_RX_DATA_VALID,
   input  wire        I_RX_STATUS_VALID,
   input  wire        I_RX_IS_PAUSE,
   input  wire [15:0] I_RX_PAUSE_QUANTA,
   input  wire        I_RX_ADDR_PASS,
   input  wire        I_PROMISCUOUS,
   output reg  [7:0]  O_RX_DATA,
   output reg         O_RX_DATA_VALID,
   output reg         O_RX_STATUS_VALID,
   output reg         O_RX_PACKET_FILTER
);

   localparam SEL_NONE = 2'd0;
   localparam SEL_ACC  = 2'd1;
   localparam SEL_DATA = 2'd2;
   localparam SEL_FLOW = 2'd3;
   localparam [31:0] RST_AC = `MPPC_RST_ACCESS, RST_DT = `MPPC_RST_DATA, RST_FL = `MPPC_RST_FLOW;
   // Bus side state.
   reg        wr_pend_ff;
   reg        rd_pend_ff;
   reg [1:0]  sel_ff;

   // Management access register and data register.
   reg [4:0]  phy_addr_ff;
   reg [4:0]  phy_reg_index_ff;
   reg        phy_write_select_ff;
   reg        phy_access_busy_ff;
   reg [15:0] phy_data_ff;
   reg        mdio_start_ff;
   reg        int_sel_ff;

   // Flow control register and state.
   reg [15:0] pause_time_value_ff;
   reg        pass_pause_frames_ff;
   reg        pause_ctrl_enable_ff;
   reg        flow_req_d_ff;
   reg [15:0] quanta_ff;
   reg [15:0] slot_cnt_ff;

   reg [15:0] nxt_quanta;
   reg [15:0] nxt_slot_cnt;
   reg        nxt_pause_tx;
   reg [31:0] nxt_rdata;

   wire        mdio_done;
   wire [15:0] mdio_rdata;
   wire        mdio_mdc;
   wire        mdio_mdo;
   wire        mdio_oe;

   wire addr_ph   = I_HSEL && I_HTRANS[1] && I_HREADY;
   wire busy_wr   = wr_pend_ff && (sel_ff == SEL_ACC || sel_ff == SEL_DATA);
   wire fd_active = pause_ctrl_enable_ff && I_FULL_DUPLEX;
   wire pause_seen = I_RX_STATUS_VALID && I_RX_IS_PAUSE && fd_active;
   wire pause_ctrl_busy = O_PAUSE_TX_REQ || O_BACKPRESSURE;

   // Decode of a word address to one of the three registers.
   function [1:0] reg_sel;
      input [31:0] addr;
      begin
         if (addr[31:8] != 24'h00_0000 || addr[1:0] != 2'b00)
            reg_sel = SEL_NONE;
         else if (addr[7:2] == `MPPC_IDX_ACCESS)
            reg_sel = SEL_ACC;
         else if (addr[7:2] == `MPPC_IDX_DATA)
            reg_sel = SEL_DATA;
         else if (addr[7:2] == `MPPC_IDX_FLOW)
            reg_sel = SEL_FLOW;
         else
            reg_sel = SEL_NONE;
      end
   endfunction

   mppc_mdio #(
      .HALF_CYC (MDC_HALF)
   ) u_mdio (
      .i_clk    (I_CLK),
      .i_rst    (I_SYS_RST),
      .i_start  (mdio_start_ff),
      .i_wr     (phy_write_select_ff),
      .i_phy    (phy_addr_ff),
      .i_reg    (phy_reg_index_ff),
      .i_wdata  (phy_data_ff),
      .i_mdi    (int_sel_ff ? I_INT_MDIO_I : I_EXT_MDIO_I),
      .o_done   (mdio_done),
      .o_rdata  (mdio_rdata),
      .o_mdc    (mdio_mdc),
      .o_mdo    (mdio_mdo),
      .o_mdo_oe (mdio_oe)
   );

   // Read mux; reserved bits come back as zero.
   always @*
   begin
      nxt_rdata = 32'h0000_0000;
      if (sel_ff == SEL_ACC)
      begin
         nxt_rdata[`MPPC_ACC_PHY_HI:`MPPC_ACC_PHY_LO] = phy_addr_ff;
         nxt_rdata[`MPPC_ACC_IDX_HI:`MPPC_ACC_IDX_LO] = phy_reg_index_ff;
         nxt_rdata[`MPPC_ACC_WR_BIT]                  = phy_write_select_ff;
         nxt_rdata[`MPPC_ACC_BUSY_BIT]                = phy_access_busy_ff;
      end
      else if (sel_ff == SEL_DATA)
         nxt_rdata[`MPPC_DATA_HI:0] = phy_data_ff;
      else if (sel_ff == SEL_FLOW)
      begin
         nxt_rdata[`MPPC_FLOW_PT_HI:`MPPC_FLOW_PT_LO] = pause_time_value_ff;
         nxt_rdata[`MPPC_FLOW_PASS_BIT]               = pass_pause_frames_ff;
         nxt_rdata[`MPPC_FLOW_EN_BIT]                 = pause_ctrl_enable_ff;
         nxt_rdata[`MPPC_FLOW_BUSY_BIT]               = pause_ctrl_busy;
      end
   end

   // Bus slave: writes finish with no wait state, reads insert one so the
   // data always reflects a write that ended just before.
   always @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         wr_pend_ff  <= 1'b0;
         rd_pend_ff  <= 1'b0;
         sel_ff      <= SEL_NONE;
         O_HREADYOUT <= 1'b1;
         O_HRDATA    <= 32'h0000_0000;
         O_HRESP     <= 1'b0;
      end
      else
      begin
         O_HRESP    <= 1'b0;
         wr_pend_ff <= addr_ph && I_HWRITE;
         if (addr_ph)
            sel_ff <= reg_sel(I_HADDR);
         if (rd_pend_ff)
         begin
            rd_pend_ff  <= 1'b0;
            O_HREADYOUT <= 1'b1;
            O_HRDATA    <= nxt_rdata;
         end
         else if (addr_ph && !I_HWRITE)
         begin
            rd_pend_ff  <= 1'b1;
            O_HREADYOUT <= 1'b0;
         end
      end
   end

   // Management registers. Writes while an access runs are dropped so the
   // frame in flight keeps its address, index and data.
   always @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         phy_addr_ff         <= RST_AC[`MPPC_ACC_PHY_HI:`MPPC_ACC_PHY_LO];
         phy_reg_index_ff    <= 5'h00;
         phy_write_select_ff <= 1'b0;
         phy_access_busy_ff  <= 1'b0;
         phy_data_ff         <= RST_DT[`MPPC_DATA_HI:0];
         mdio_start_ff       <= 1'b0;
         int_sel_ff          <= 1'b0;
      end
      else
      begin
         mdio_start_ff <= 1'b0;
         if (wr_pend_ff && sel_ff == SEL_ACC && !phy_access_busy_ff)
         begin
            phy_addr_ff         <= I_HWDATA[`MPPC_ACC_PHY_HI:`MPPC_ACC_PHY_LO];
            phy_reg_index_ff    <= I_HWDATA[`MPPC_ACC_IDX_HI:`MPPC_ACC_IDX_LO];
            phy_write_select_ff <= I_HWDATA[`MPPC_ACC_WR_BIT];
            int_sel_ff <= (I_HWDATA[`MPPC_ACC_PHY_HI:`MPPC_ACC_PHY_LO] == `MPPC_INT_PHY_ADDR);
            if (I_HWDATA[`MPPC_ACC_BUSY_BIT])
            begin
               phy_access_busy_ff <= 1'b1;
               mdio_start_ff      <= 1'b1;
            end
         end
         else if (mdio_done)
            phy_access_busy_ff <= 1'b0;
         if (wr_pend_ff && sel_ff == SEL_DATA && !phy_access_busy_ff)
            phy_data_ff <= I_HWDATA[`MPPC_DATA_HI:0];
         else if (mdio_done && !phy_write_select_ff)
            phy_data_ff <= mdio_rdata;
      end
   end

   // Only the selected end sees clock and data; the other stays quiet.
   always @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         O_EXT_MDC     <= 1'b0;
         O_EXT_MDIO_O  <= 1'b0;
         O_EXT_MDIO_OE <= 1'b0;
         O_INT_MDC     <= 1'b0;
         O_INT_MDIO_O  <= 1'b0;
         O_INT_MDIO_OE <= 1'b0;
      end
      else
      begin
         O_INT_MDC     <= int_sel_ff && mdio_mdc;
         O_INT_MDIO_O  <= int_sel_ff && mdio_mdo;
         O_INT_MDIO_OE <= int_sel_ff && mdio_oe;
         O_EXT_MDC     <= !int_sel_ff && mdio_mdc;
         O_EXT_MDIO_O  <= !int_sel_ff && mdio_mdo;
         O_EXT_MDIO_OE <= !int_sel_ff && mdio_oe;
      end
   end

   // Received pause countdown: quanta times slot time, reloaded by each new
   // pause frame and dropped when pause handling is switched off.
   always @*
   begin
      nxt_quanta   = quanta_ff;
      nxt_slot_cnt = slot_cnt_ff;
      if (!fd_active)
      begin
         nxt_quanta   = 16'h0000;
         nxt_slot_cnt = 16'h0000;
      end
      else if (pause_seen)
      begin
         nxt_quanta   = I_RX_PAUSE_QUANTA;
         nxt_slot_cnt = SLOT_CYC[15:0] - 16'h0001;
      end
      else if (quanta_ff != 16'h0000)
      begin
         if (slot_cnt_ff == 16'h0000)
         begin
            nxt_quanta   = quanta_ff - 16'h0001;
            nxt_slot_cnt = SLOT_CYC[15:0] - 16'h0001;
         end
         else
            nxt_slot_cnt = slot_cnt_ff - 16'h0001;
      end
   end

   // A new request wins over a completion that lands in the same cycle.
   always @*
   begin
      nxt_pause_tx = O_PAUSE_TX_REQ;
      if (fd_active && I_TX_ENABLE && I_FLOW_REQ && !flow_req_d_ff)
         nxt_pause_tx = 1'b1;
      else if (I_PAUSE_TX_DONE || !I_TX_ENABLE || !fd_active)
         nxt_pause_tx = 1'b0;
   end

   // Flow control register, pause transmit and backpressure.
   always @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         pause_time_value_ff  <= RST_FL[`MPPC_FLOW_PT_HI:`MPPC_FLOW_PT_LO];
         pass_pause_frames_ff <= 1'b0;
         pause_ctrl_enable_ff <= 1'b0;
         flow_req_d_ff        <= 1'b0;
         quanta_ff            <= 16'h0000;
         slot_cnt_ff          <= 16'h0000;
         O_PAUSE_TX_REQ       <= 1'b0;
         O_PAUSE_TIME         <= 16'h0000;
         O_BACKPRESSURE       <= 1'b0;
         O_TX_HOLD            <= 1'b0;
      end
      else
      begin
         // Writes are taken even while busy so software can always stop
         // backpressure; bit 0 is read-only and the write value is dropped.
         if (wr_pend_ff && sel_ff == SEL_FLOW)
         begin
            pause_time_value_ff  <= I_HWDATA[`MPPC_FLOW_PT_HI:`MPPC_FLOW_PT_LO];
            pass_pause_frames_ff <= I_HWDATA[`MPPC_FLOW_PASS_BIT];
            pause_ctrl_enable_ff <= I_HWDATA[`MPPC_FLOW_EN_BIT];
         end
         flow_req_d_ff  <= I_FLOW_REQ;
         quanta_ff      <= nxt_quanta;
         slot_cnt_ff    <= nxt_slot_cnt;
         O_PAUSE_TX_REQ <= nxt_pause_tx;
         if (nxt_pause_tx && !O_PAUSE_TX_REQ)
            O_PAUSE_TIME <= pause_time_value_ff;
         O_BACKPRESSURE <= pause_ctrl_enable_ff && !I_FULL_DUPLEX
                           && I_TX_ENABLE && I_FLOW_REQ;
         O_TX_HOLD      <= (nxt_quanta != 16'h0000);
      end
   end

   // Receive path: every frame's data passes; only the status is marked.
   always @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         O_RX_DATA          <= 8'h00;
         O_RX_DATA_VALID    <= 1'b0;
         O_RX_STATUS_VALID  <= 1'b0;
         O_RX_PACKET_FILTER <= 1'b0;
      end
      else
      begin
         O_RX_DATA         <= I_RX_DATA;
         O_RX_DATA_VALID   <= I_RX_DATA_VALID;
         O_RX_STATUS_VALID <= I_RX_STATUS_VALID;
         if (I_RX_STATUS_VALID)
         begin
            if (I_PROMISCUOUS)
               O_RX_PACKET_FILTER <= 1'b1;
            else if (pause_seen)
               O_RX_PACKET_FILTER <= pass_pause_frames_ff;
            else
               O_RX_PACKET_FILTER <= I_RX_ADDR_PASS;
         end
      end
   end

endmodule

// ===== tb/mppc_monitor.sv
// Port-level assertions for the PHY management and pause block.
module mppc_monitor (
   input logic        I_CLK,
   input logic        I_SYS_RST,
   input logic        I_HSEL,
   input logic [1:0]  I_HTRANS,
   input logic        I_HWRITE,
   input logic        I_HREADY,
   input logic        O_HREADYOUT,
   input logic        O_EXT_MDC,
   input logic        O_EXT_MDIO_OE,
   input logic        O_INT_MDC,
   input logic        I_FULL_DUPLEX,
   input logic        I_TX_ENABLE,
   input logic        I_FLOW_REQ,
   input logic        O_PAUSE_TX_REQ,
   input logic [15:0] O_PAUSE_TIME,
   input logic        I_PAUSE_TX_DONE,
   input logic        O_BACKPRESSURE,
   input logic        O_TX_HOLD,
   input logic [7:0]  I_RX_DATA,
   input logic        I_RX_DATA_VALID,
   input logic        I_RX_STATUS_VALID,
   input logic        I_RX_IS_PAUSE,
   input logic        I_PROMISCUOUS,
   input logic [7:0]  O_RX_DATA,
   input logic        O_RX_DATA_VALID,
   input logic        O_RX_STATUS_VALID,
   input logic        O_RX_PACKET_FILTER
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_SYS_RST);
   sequence s_rd_req;
      I_HSEL && I_HTRANS[1] && I_HREADY && !I_HWRITE;
   endsequence
   sequence s_rd_wait;
      !O_HREADYOUT ##1 O_HREADYOUT;
   endsequence
   AST_RD_WAIT: assert property (s_rd_req |=> s_rd_wait)
      else $error("read wait state wrong");
   AST_TX_OFF: assert property (!I_TX_ENABLE |=> !O_PAUSE_TX_REQ && !O_BACKPRESSURE)
      else $error("flow output while transmitter off");
   AST_BP_CAUSE: assert property (O_BACKPRESSURE |->
      $past(!I_FULL_DUPLEX && I_TX_ENABLE && I_FLOW_REQ))
      else $error("backpressure without cause");
   AST_DONE_CLR: assert property (O_PAUSE_TX_REQ && I_PAUSE_TX_DONE &&
      !$rose(I_FLOW_REQ) |=> !O_PAUSE_TX_REQ)
      else $error("pause request kept after done");
   // The cycle after a done is excused; the time is captured only when the request rises, so a new request then keeps it.
   AST_PT_HOLD: assert property (O_PAUSE_TX_REQ && $past(O_PAUSE_TX_REQ) &&
      !$past(I_PAUSE_TX_DONE) |-> $stable(O_PAUSE_TIME))
      else $error("pause time moved during request");
   AST_HOLD_CAUSE: assert property ($rose(O_TX_HOLD) |->
      $past(I_RX_STATUS_VALID && I_RX_IS_PAUSE && I_FULL_DUPLEX))
      else $error("transmit hold without pause frame");
   AST_RX_FWD: assert property (I_RX_DATA_VALID |=>
      O_RX_DATA_VALID && O_RX_DATA == $past(I_RX_DATA))
      else $error("received byte not forwarded");
   AST_PROMISC: assert property (I_RX_STATUS_VALID && I_PROMISCUOUS |=>
      O_RX_STATUS_VALID && O_RX_PACKET_FILTER)
      else $error("promiscuous frame not flagged");
   AST_EXT_QUIET: assert property (O_INT_MDC |-> !O_EXT_MDC && !O_EXT_MDIO_OE)
      else $error("external pins active during internal access");
endmodule

// ===== tb/mppc_phy_model.sv
// Behavioural PHY on one management wire: records each frame and answers reads.
module mppc_phy_model #(
   parameter logic [15:0] RD_VAL = 16'h0000
)(
   input  wire logic   i_clk,
   input  wire logic   i_rst,
   input  wire logic   i_mdc,
   input  wire logic   i_mdo,
   input  wire logic   i_oe,
   output logic        o_mdi,
   output logic [63:0] o_frame,
   output logic [7:0]  o_count
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [63:0] sh_ff;
   logic [6:0]  cnt_ff;
   logic        drv_ff;
   logic        mdc_ff;
   // The wire has a pull-up, so a released line reads one.
   assign o_mdi = i_oe ? i_mdo : drv_ff;
   always @(posedge i_clk)
   begin
      mdc_ff <= i_mdc;
      if (i_rst)
      begin
         cnt_ff <= 7'h00;
         drv_ff <= 1'b1;
         o_count <= 8'h00;
         o_frame <= 64'h0;
      end
      else if (i_mdc && !mdc_ff)
      begin
         sh_ff <= {sh_ff[62:0], o_mdi};
         cnt_ff <= (cnt_ff == 7'h3F) ? 7'h00 : cnt_ff + 7'h01;
         if (cnt_ff == 7'h3F)
         begin
            o_frame <= {sh_ff[62:0], o_mdi};
            o_count <= o_count + 8'h01;
         end
      end
      else if (!i_mdc && mdc_ff)
         drv_ff <= (cnt_ff == 7'h2F) ? 1'b0 :
                   (cnt_ff > 7'h2F) ? RD_VAL[7'h3F - cnt_ff] : 1'b1;
   end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the PHY management and pause block.
`include "mppc_defines.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] A_ACC = {`MPPC_IDX_ACCESS, 2'h0};
   localparam logic [7:0] A_DAT = {`MPPC_IDX_DATA, 2'h0};
   localparam logic [7:0] A_FLW = {`MPPC_IDX_FLOW, 2'h0};
   logic        I_CLK = 0, I_SYS_RST = 1, I_HSEL = 1, I_HWRITE = 0;
   logic [31:0] I_HADDR = '0, I_HWDATA = '0, O_HRDATA, rd;
   logic [1:0]  I_HTRANS = '0;
   logic [2:0]  I_HSIZE = 3'h2;
   logic        I_FULL_DUPLEX = 0, I_TX_ENABLE = 0, I_FLOW_REQ = 0, I_PAUSE_TX_DONE = 0;
   logic        I_RX_DATA_VALID = 0, I_RX_STATUS_VALID = 0, I_RX_IS_PAUSE = 0;
   logic        I_RX_ADDR_PASS = 0, I_PROMISCUOUS = 0;
   logic [7:0]  I_RX_DATA = '0, O_RX_DATA, int_cnt, ext_cnt;
   logic [15:0] I_RX_PAUSE_QUANTA = '0, O_PAUSE_TIME;
   wire         I_HREADY, I_EXT_MDIO_I, I_INT_MDIO_I;
   logic        O_HREADYOUT, O_HRESP, O_EXT_MDC, O_EXT_MDIO_O, O_EXT_MDIO_OE;
   logic        O_INT_MDC, O_INT_MDIO_O, O_INT_MDIO_OE, O_PAUSE_TX_REQ, O_BACKPRESSURE;
   logic        O_TX_HOLD, O_RX_DATA_VALID, O_RX_STATUS_VALID, O_RX_PACKET_FILTER;
   logic [63:0] int_frame, ext_frame;
   int          mismatches = 0, total_checks = 0;
   always #10 I_CLK = ~I_CLK;
   assign I_HREADY = O_HREADYOUT;
   mppc_top #(.SLOT_CYC(4), .MDC_HALF(3)) i_mppc_top (.*);
   mppc_phy_model #(.RD_VAL(16'hBEEF)) i_mppc_phy_model_int (.i_clk(I_CLK),
      .i_rst(I_SYS_RST), .i_mdc(O_INT_MDC), .i_mdo(O_INT_MDIO_O), .i_oe(O_INT_MDIO_OE),
      .o_mdi(I_INT_MDIO_I), .o_frame(int_frame), .o_count(int_cnt));
   mppc_phy_model #(.RD_VAL(16'h5A3C)) i_mppc_phy_model_ext (.i_clk(I_CLK),
      .i_rst(I_SYS_RST), .i_mdc(O_EXT_MDC), .i_mdo(O_EXT_MDIO_O), .i_oe(O_EXT_MDIO_OE),
      .o_mdi(I_EXT_MDIO_I), .o_frame(ext_frame), .o_count(ext_cnt));
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      total_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      @(negedge I_CLK);
      while (O_HREADYOUT !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            chk("hready_wait", 1, 0);
            wrap_up();
         end
         @(negedge I_CLK);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge I_CLK);
      I_HTRANS <= 2'h2;
      I_HADDR <= {24'h00_0000, a};
      I_HWRITE <= w;
      wait_rdy();
      @(posedge I_CLK);
      I_HTRANS <= 2'h0;
      I_HWDATA <= d;
      wait_rdy();
      rd = O_HRDATA;
      @(posedge I_CLK);
   endtask
   task automatic settle();
      repeat (3) @(posedge I_CLK);
      @(negedge I_CLK);
   endtask
   task automatic poll();
      int n;
      n = 0;
      do
      begin
         bus(0, A_ACC, '0);
         n++;
      end
      while (rd[0] !== 1'b0 && n < 400);
      if (rd[0] !== 1'b0)
      begin
         chk("busy_wait", 0, 1);
         wrap_up();
      end
   endtask
   task automatic rx(input logic [2:0] v, input logic [15:0] q);
      @(posedge I_CLK);
      {I_PROMISCUOUS, I_RX_ADDR_PASS, I_RX_IS_PAUSE} <= v;
      I_RX_PAUSE_QUANTA <= q;
      I_RX_STATUS_VALID <= 1;
      I_RX_DATA_VALID <= 1;
      I_RX_DATA <= {5'h00, v} ^ 8'hA5;
      @(posedge I_CLK);
      I_RX_STATUS_VALID <= 0;
      I_RX_DATA_VALID <= 0;
      @(negedge I_CLK);
      chk("rx_data", {5'h00, v} ^ 8'hA5, O_RX_DATA);
      chk("rx_stat", 1, O_RX_STATUS_VALID);
   endtask
   task automatic t_regs();
      bus(0, A_ACC, '0);
      chk("acc_rst", `MPPC_RST_ACCESS, rd);
      bus(0, A_FLW, '0);
      chk("flow_rst", `MPPC_RST_FLOW, rd);
      bus(1, A_DAT, 32'hFFFF_ABCD);
      bus(0, A_DAT, '0);
      chk("dat_rsv", 32'h0000_ABCD, rd);
      bus(1, A_ACC, 32'hFFFF_FFFE);
      bus(0, A_ACC, '0);
      chk("acc_rsv", 32'h0000_FFC2, rd);
      bus(1, A_FLW, 32'h0A5A_FFFE);
      bus(0, A_FLW, '0);
      chk("flow_rsv", 32'h0A5A_0006, rd);
      bus(1, 8'h24, 32'h1234_5678);
      bus(0, 8'h24, '0);
      chk("unmapped", 0, rd);
      chk("hresp", 0, O_HRESP);
      repeat (400) @(negedge I_CLK);
      chk("no_frame", 0, {int_cnt, ext_cnt});
      $display("test regs done");
   endtask
   task automatic t_mgmt(input logic [31:0] acc, input logic [63:0] fr,
                         input logic [15:0] dv, input logic ext);
      logic [7:0] ci, ce;
      ci = int_cnt;
      ce = ext_cnt;
      poll();
      bus(1, A_DAT, 32'h0000_1234);
      bus(1, A_ACC, acc);
      bus(0, A_ACC, '0);
      chk("busy_set", 1, rd[0]);
      poll();
      chk("acc_done", acc & 32'h0000_FFC2, rd);
      bus(0, A_DAT, '0);
      chk("data", {16'h0000, dv}, rd);
      chk("frame", fr, ext ? ext_frame : int_frame);
      chk("int_cnt", ci + !ext, int_cnt);
      chk("ext_cnt", ce + ext, ext_cnt);
      $display("test mgmt %h done", acc);
   endtask
   task automatic t_flow();
      I_FULL_DUPLEX <= 1;
      I_TX_ENABLE <= 1;
      bus(1, A_FLW, 32'h0A5A_0000);
      bus(1, A_FLW, 32'h0A5A_0002);
      I_FLOW_REQ <= 1;
      settle();
      chk("ptx_req", 1, O_PAUSE_TX_REQ);
      chk("ptime", 16'h0A5A, O_PAUSE_TIME);
      bus(0, A_FLW, '0);
      chk("fbusy", 32'h0A5A_0003, rd);
      @(posedge I_CLK);
      I_PAUSE_TX_DONE <= 1;
      @(posedge I_CLK);
      I_PAUSE_TX_DONE <= 0;
      I_FLOW_REQ <= 0;
      I_TX_ENABLE <= 0;
      settle();
      chk("ptx_done", 0, O_PAUSE_TX_REQ);
      @(posedge I_CLK);
      I_FLOW_REQ <= 1;
      settle();
      chk("ptx_off", 0, O_PAUSE_TX_REQ);
      @(posedge I_CLK);
      I_FULL_DUPLEX <= 0;
      settle();
      chk("bp_off", 0, O_BACKPRESSURE);
      @(posedge I_CLK);
      I_TX_ENABLE <= 1;
      settle();
      chk("bp_on", 1, O_BACKPRESSURE);
      bus(0, A_FLW, '0);
      chk("bp_busy", 32'h0A5A_0003, rd);
      I_FLOW_REQ <= 0;
      settle();
      bus(0, A_FLW, '0);
      chk("bp_clr", 32'h0A5A_0002, rd);
      bus(1, A_FLW, 32'h0A5A_0000);
      I_FLOW_REQ <= 1;
      settle();
      chk("bp_dis", 0, O_BACKPRESSURE);
      @(posedge I_CLK);
      I_FLOW_REQ <= 0;
      $display("test flow done");
   endtask
   task automatic t_pause_rx();
      int n;
      I_FULL_DUPLEX <= 1;
      bus(1, A_FLW, 32'h0A5A_0002);
      rx(3'h1, 16'h0003);
      n = 0;
      while (O_TX_HOLD === 1'b1 && n < 100)
      begin
         n++;
         @(negedge I_CLK);
      end
      chk("hold_len", 1, n >= 11 && n <= 13);
      bus(1, A_FLW, 32'h0A5A_0004);
      rx(3'h1, 16'h0003);
      chk("hold_dis", 0, O_TX_HOLD);
      chk("filt_dis", 0, O_RX_PACKET_FILTER);
      $display("test pause rx done");
   endtask
   task automatic t_filter();
      // Each entry holds pass bit, promiscuous, address pass, pause and the expected flag.
      logic [4:0] tv [5] = '{5'h13, 5'h06, 5'h0B, 5'h05, 5'h10};
      foreach (tv[k])
      begin
         bus(1, A_FLW, {16'h0A5A, 13'h0000, tv[k][4], 2'h2});
         rx(tv[k][3:1], 16'h0000);
         chk("filter", tv[k][0], O_RX_PACKET_FILTER);
      end
      $display("test filter done");
   endtask
   initial
   begin
      repeat (8) @(posedge I_CLK);
      I_SYS_RST <= 0;
      t_regs();
      t_mgmt(32'h0000_0943, {32'hFFFF_FFFF, 4'h5, 5'h01, 5'h05, 2'h2, 16'h1234},
             16'h1234, 0);
      t_mgmt(32'h0000_0881, {32'hFFFF_FFFF, 4'h6, 5'h01, 5'h02, 2'h2, 16'hBEEF},
             16'hBEEF, 0);
      t_mgmt(32'h0000_1801, {32'hFFFF_FFFF, 4'h6, 5'h03, 5'h00, 2'h2, 16'h5A3C},
             16'h5A3C, 1);
      t_flow();
      t_pause_rx();
      t_filter();
      wrap_up();
   end
endmodule
bind mppc_top mppc_monitor i_mppc_monitor (.*);
